// file: rtl/icdr_collector.sv
// interrupt collector for two sources with debug read and flag registers
// assumes a zero-wait peripheral bus slave port and sources on clk_i
`include "icdr_consts.svh"

module icdr_collector (
    input  wire logic                       clk_i,
    input  wire logic                       nrst_i,
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [`ICDR_ADDR_W-1:0]    paddr_i,
    input  wire logic [`ICDR_DATA_W-1:0]    pwdata_i,
    output logic      [`ICDR_DATA_W-1:0]    prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    input  wire logic [`ICDR_NUM_SRC-1:0]   src_req_i,
    input  wire logic                       irq_ack_i,
    input  wire logic                       irq_done_i,
    output logic                            irq_o,
    output logic      [`ICDR_VEC_W-1:0]     irq_vector_o,
    output icdr_pkg::icdr_prio_t            irq_level_o,
    output logic                            fast_interrupt_line_o,
    output logic      [`ICDR_DATA_W-1:0]    debug_flag_o
);

    // address decode, shared by read and write paths
    function automatic icdr_pkg::icdr_reg_e icdr_decode(input logic [`ICDR_ADDR_W-1:0] a);
        logic [`ICDR_ADDR_W-1:0] base;
        base = {a[`ICDR_ADDR_W-1:4], 4'h0};
        icdr_decode = icdr_pkg::ICDR_REG_NONE;
        if (a[1:0] == 2'h0) begin
            if (base == `ICDR_OFS_SRC117) begin
                icdr_decode = icdr_pkg::ICDR_REG_SRC117;
            end else if (base == `ICDR_OFS_SRC118) begin
                icdr_decode = icdr_pkg::ICDR_REG_SRC118;
            end else if (base == `ICDR_OFS_DBG_A) begin
                icdr_decode = icdr_pkg::ICDR_REG_DBG_A;
            end else if (base == `ICDR_OFS_DBG_B) begin
                icdr_decode = icdr_pkg::ICDR_REG_DBG_B;
            end else if (base == `ICDR_OFS_FLAG) begin
                icdr_decode = icdr_pkg::ICDR_REG_FLAG;
            end else if (base == `ICDR_OFS_STAT) begin
                icdr_decode = icdr_pkg::ICDR_REG_STAT;
            end
        end
    endfunction

    // apply an alias operation to a full word
    function automatic logic [`ICDR_DATA_W-1:0] icdr_alias_op(
        input logic [1:0]              op,
        input logic [`ICDR_DATA_W-1:0] cur,
        input logic [`ICDR_DATA_W-1:0] wd
    );
        unique case (op)
            `ICDR_ALIAS_PLAIN: icdr_alias_op = wd;
            `ICDR_ALIAS_SET:   icdr_alias_op = cur | wd;
            `ICDR_ALIAS_CLR:   icdr_alias_op = cur & ~wd;
            `ICDR_ALIAS_TOG:   icdr_alias_op = cur ^ wd;
        endcase
    endfunction

    icdr_pkg::icdr_reg_e                 reg_sel;
    logic                                setup_rd;
    logic                                setup_any;
    logic                                access_wr;
    logic [1:0]                          alias_sel;

    logic [`ICDR_CFG_W-1:0]              cfg       [`ICDR_NUM_SRC];
    logic [`ICDR_NUM_SRC-1:0]            main_req;
    logic [`ICDR_NUM_SRC-1:0]            fast_req;
    icdr_pkg::icdr_prio_t                level     [`ICDR_NUM_SRC];

    logic                                any_req;
    logic [`ICDR_VEC_W-1:0]              win_vec;
    icdr_pkg::icdr_prio_t                win_lvl;

    icdr_pkg::icdr_state_e               state_r;
    icdr_pkg::icdr_state_e               state_nxt;
    logic [`ICDR_VEC_W-1:0]              vector_r;
    icdr_pkg::icdr_prio_t                level_r;
    logic                                fast_r;
    logic [`ICDR_DATA_W-1:0]             flag_r;
    logic [`ICDR_DATA_W-1:0]             prdata_r;
    logic                                pslverr_r;
    logic [`ICDR_DATA_W-1:0]             stat_word;

    assign reg_sel   = icdr_decode(paddr_i);
    assign alias_sel = paddr_i[3:2];
    assign setup_any = psel_i & ~penable_i;
    assign setup_rd  = setup_any & ~pwrite_i;
    assign access_wr = psel_i & penable_i & pwrite_i;

    // one configuration cell per source
    generate
        for (genvar g = 0; g < `ICDR_NUM_SRC; g++) begin : g_src
            localparam icdr_pkg::icdr_reg_e SRC_REG =
                (g == 0) ? icdr_pkg::ICDR_REG_SRC117 : icdr_pkg::ICDR_REG_SRC118;
            icdr_src_cfg u_cfg (
                .clk_i      (clk_i),
                .nrst_i     (nrst_i),
                .wr_en_i    (access_wr && (reg_sel == SRC_REG)),
                .alias_i    (alias_sel),
                .wdata_i    (pwdata_i[`ICDR_CFG_W-1:0]),
                .hw_req_i   (src_req_i[g]),
                .cfg_o      (cfg[g]),
                .main_req_o (main_req[g]),
                .fast_req_o (fast_req[g]),
                .level_o    (level[g])
            );
        end
    endgenerate

    // priority pick among normal requests, later source wins a tie
    always_comb begin
        any_req = 1'b0;
        win_vec = `ICDR_VEC_FIRST;
        win_lvl = 2'h0;
        for (int i = 0; i < `ICDR_NUM_SRC; i++) begin
            if (main_req[i] && (!any_req || (level[i] >= win_lvl))) begin
                any_req = 1'b1;
                win_vec = `ICDR_VEC_FIRST + i[`ICDR_VEC_W-1:0];
                win_lvl = level[i];
            end
        end
    end

    // main request state machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            icdr_pkg::ICDR_IDLE: begin
                if (any_req) begin
                    state_nxt = icdr_pkg::ICDR_ASSERT;
                end
            end
            icdr_pkg::ICDR_ASSERT: begin
                if (irq_ack_i) begin
                    state_nxt = icdr_pkg::ICDR_SERVICE;
                end
            end
            icdr_pkg::ICDR_SERVICE: begin
                if (irq_done_i) begin
                    state_nxt = icdr_pkg::ICDR_IDLE;
                end
            end
            default: state_nxt = icdr_pkg::ICDR_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= icdr_pkg::ICDR_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // winner is captured when the request is raised
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vector_r <= `ICDR_VEC_FIRST;
            level_r  <= 2'h0;
        end else if ((state_r == icdr_pkg::ICDR_IDLE) && any_req) begin
            vector_r <= win_vec;
            level_r  <= win_lvl;
        end
    end

    // fast line bypasses the state machine and priority
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fast_r <= 1'b0;
        end else begin
            fast_r <= |fast_req;
        end
    end

    // debug flag, written and read back over the bus, never read by interrupt logic
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_r <= `ICDR_FLAG_RESET;
        end else if (access_wr && (reg_sel == icdr_pkg::ICDR_REG_FLAG)) begin
            flag_r <= icdr_alias_op(alias_sel, flag_r, pwdata_i);
        end
    end

    always_comb begin
        stat_word = '0;
        stat_word[`ICDR_STAT_STATE_LSB +: 3]         = state_r;
        stat_word[`ICDR_STAT_VEC_LSB +: `ICDR_VEC_W] = vector_r;
        stat_word[`ICDR_STAT_LVL_LSB +: 2]           = level_r;
        stat_word[`ICDR_STAT_IRQ]                    = (state_r == icdr_pkg::ICDR_ASSERT);
        stat_word[`ICDR_STAT_FAST]                   = fast_r;
    end

    // read data is prepared in the setup phase and shown in the access phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_r <= '0;
        end else if (setup_rd) begin
            unique case (reg_sel)
                icdr_pkg::ICDR_REG_SRC117:
                    prdata_r <= {{(`ICDR_DATA_W-`ICDR_CFG_W){1'b0}}, cfg[0]};
                icdr_pkg::ICDR_REG_SRC118:
                    prdata_r <= {{(`ICDR_DATA_W-`ICDR_CFG_W){1'b0}}, cfg[1]};
                icdr_pkg::ICDR_REG_DBG_A:  prdata_r <= `ICDR_DBG_A_VALUE;
                icdr_pkg::ICDR_REG_DBG_B:  prdata_r <= `ICDR_DBG_B_VALUE;
                icdr_pkg::ICDR_REG_FLAG:   prdata_r <= flag_r;
                icdr_pkg::ICDR_REG_STAT:   prdata_r <= stat_word;
                icdr_pkg::ICDR_REG_NONE:   prdata_r <= '0;
                default:                   prdata_r <= '0;
            endcase
        end
    end

    // unmapped or misaligned addresses answer with an error
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pslverr_r <= 1'b0;
        end else if (setup_any) begin
            pslverr_r <= (reg_sel == icdr_pkg::ICDR_REG_NONE);
        end
    end

    assign pready_o              = 1'b1;
    assign prdata_o              = prdata_r;
    assign pslverr_o             = pslverr_r & psel_i & penable_i;
    assign irq_o                 = (state_r == icdr_pkg::ICDR_ASSERT);
    assign irq_vector_o          = vector_r;
    assign irq_level_o           = level_r;
    assign fast_interrupt_line_o = fast_r;
    assign debug_flag_o          = flag_r;

endmodule

// file: rtl/icdr_consts.svh
// offsets, field positions, reset values and fixed patterns of the collector
// assumes a 13-bit byte address on the peripheral bus, word aligned registers
`ifndef ICDR_CONSTS_SVH
`define ICDR_CONSTS_SVH

`define ICDR_ADDR_W         13
`define ICDR_DATA_W         32
`define ICDR_NUM_SRC        2

// register base offsets; SRC117, SRC118 and FLAG are each followed by set, clear and toggle aliases
`define ICDR_OFS_SRC117     13'h0870
`define ICDR_OFS_SRC118     13'h0880
`define ICDR_OFS_DBG_A      13'h1130
`define ICDR_OFS_DBG_B      13'h1140
`define ICDR_OFS_FLAG       13'h1150
`define ICDR_OFS_STAT       13'h1160

// alias selector, address bits 3:2
`define ICDR_ALIAS_PLAIN    2'h0
`define ICDR_ALIAS_SET      2'h1
`define ICDR_ALIAS_CLR      2'h2
`define ICDR_ALIAS_TOG      2'h3

// source configuration fields
`define ICDR_CFG_W          5
`define ICDR_CFG_PRIO_MSB   1
`define ICDR_CFG_PRIO_LSB   0
`define ICDR_CFG_ENABLE     2
`define ICDR_CFG_SOFT       3
`define ICDR_CFG_FAST       4
`define ICDR_CFG_RESET      5'h00

// vector number of the first source
`define ICDR_VEC_W          7
`define ICDR_VEC_FIRST      7'h75

// fixed read patterns and debug flag reset
`define ICDR_DBG_A_VALUE    32'hECA94567
`define ICDR_DBG_B_VALUE    32'h1356DA98
`define ICDR_FLAG_RESET     32'h00000000

// status register fields
`define ICDR_STAT_STATE_LSB  0
`define ICDR_STAT_VEC_LSB    8
`define ICDR_STAT_LVL_LSB    16
`define ICDR_STAT_IRQ        20
`define ICDR_STAT_FAST       21

`endif

// file: rtl/icdr_pkg.sv
// types shared by the interrupt collector and its source configuration blocks
// assumes icdr_consts.svh for all numeric constants
package icdr_pkg;

    typedef logic [1:0] icdr_prio_t;

    // main request state machine, one-hot
    typedef enum logic [2:0] {
        ICDR_IDLE    = 3'b001,
        ICDR_ASSERT  = 3'b010,
        ICDR_SERVICE = 3'b100
    } icdr_state_e;

    // register selected by a bus address
    typedef enum logic [2:0] {
        ICDR_REG_NONE   = 3'h0,
        ICDR_REG_SRC117 = 3'h1,
        ICDR_REG_SRC118 = 3'h2,
        ICDR_REG_DBG_A  = 3'h3,
        ICDR_REG_DBG_B  = 3'h4,
        ICDR_REG_FLAG   = 3'h5,
        ICDR_REG_STAT   = 3'h6
    } icdr_reg_e;

endpackage

// file: rtl/icdr_src_cfg.sv
// one interrupt source: its configuration register and request routing
// assumes write strobes come from the bus slave on the same clock
`include "icdr_consts.svh"

module icdr_src_cfg (
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      wr_en_i,
    input  wire logic [1:0]                alias_i,
    input  wire logic [`ICDR_CFG_W-1:0]    wdata_i,
    input  wire logic                      hw_req_i,
    output logic      [`ICDR_CFG_W-1:0]    cfg_o,
    output logic                           main_req_o,
    output logic                           fast_req_o,
    output icdr_pkg::icdr_prio_t           level_o
);

    logic [`ICDR_CFG_W-1:0] cfg_r;
    logic [`ICDR_CFG_W-1:0] cfg_nxt;
    logic                   active;

    // plain write, set, clear or toggle of the five live bits
    always_comb begin
        cfg_nxt = cfg_r;
        unique case (alias_i)
            `ICDR_ALIAS_PLAIN: cfg_nxt = wdata_i;
            `ICDR_ALIAS_SET:   cfg_nxt = cfg_r | wdata_i;
            `ICDR_ALIAS_CLR:   cfg_nxt = cfg_r & ~wdata_i;
            `ICDR_ALIAS_TOG:   cfg_nxt = cfg_r ^ wdata_i;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_r <= `ICDR_CFG_RESET;
        end else if (wr_en_i) begin
            cfg_r <= cfg_nxt;
        end
    end

    // software bit forces a request, enable gates both kinds
    assign active     = cfg_r[`ICDR_CFG_ENABLE]
                        & (hw_req_i | cfg_r[`ICDR_CFG_SOFT]);
    assign fast_req_o = active & cfg_r[`ICDR_CFG_FAST];
    assign main_req_o = active & ~cfg_r[`ICDR_CFG_FAST];
    assign level_o    = cfg_r[`ICDR_CFG_PRIO_MSB:`ICDR_CFG_PRIO_LSB];
    assign cfg_o      = cfg_r;

endmodule

// file: tb/icdr_core_model.sv
// core model: takes normal requests with an ack, ends service with done
// assumes requests on clk_i; dly_i sets how slowly it answers
module icdr_core_model (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       irq_i,
    input  wire logic [6:0] vec_i,
    input  wire logic [1:0] lvl_i,
    input  wire logic [3:0] dly_i,
    output logic            ack_o,
    output logic            done_o,
    output logic [7:0]      svc_cnt_o,
    output logic [6:0]      vec_o,
    output logic [1:0]      lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ack_o = 1'h0;
        done_o = 1'h0;
        svc_cnt_o = 8'h00;
        vec_o = 7'h00;
        lvl_o = 2'h0;
    end

    // ack only while a request stands, done only after the ack
    always begin
        @(posedge clk_i);
        if (nrst_i && irq_i) begin
            repeat (dly_i) @(posedge clk_i);
            ack_o     <= 1'h1;
            vec_o     <= vec_i;
            lvl_o     <= lvl_i;
            svc_cnt_o <= svc_cnt_o + 8'h01;
            @(posedge clk_i);
            ack_o <= 1'h0;
            repeat (dly_i + 1) @(posedge clk_i);
            done_o <= 1'h1;
            @(posedge clk_i);
            done_o <= 1'h0;
        end
    end
endmodule

// file: tb/icdr_collector_asserts.sv
// port-level checks of the interrupt collector
// assumes icdr_consts.svh on the include path; bound into icdr_collector
`include "icdr_consts.svh"
module icdr_collector_asserts (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [12:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pslverr_o,
    input wire logic        irq_ack_i,
    input wire logic        irq_o,
    input wire logic [6:0]  irq_vector_o,
    input wire logic [31:0] debug_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    logic rd_setup;
    logic wr_acc;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign wr_acc   = psel_i && penable_i && pwrite_i;

    AST_DBG_A: assert property (rd_setup && (paddr_i & 13'h1FF3) == `ICDR_OFS_DBG_A
        |=> prdata_o == `ICDR_DBG_A_VALUE) else $error("pattern a read wrong");
    AST_DBG_B: assert property (rd_setup && (paddr_i & 13'h1FF3) == `ICDR_OFS_DBG_B
        |=> prdata_o == `ICDR_DBG_B_VALUE) else $error("pattern b read wrong");
    AST_UPPER_ZERO: assert property (rd_setup && paddr_i[1:0] == 2'h0 &&
        ((paddr_i & 13'h1FF0) inside {`ICDR_OFS_SRC117, `ICDR_OFS_SRC118})
        |=> prdata_o[31:5] == 27'h0) else $error("source upper bits not zero");
    AST_FLAG_WR: assert property (wr_acc && paddr_i == `ICDR_OFS_FLAG
        |=> debug_flag_o == $past(pwdata_i)) else $error("flag write lost");
    AST_FLAG_HOLD: assert property (!(wr_acc && (paddr_i & 13'h1FF0) == `ICDR_OFS_FLAG)
        |=> $stable(debug_flag_o)) else $error("flag changed without write");
    AST_IRQ_HOLD: assert property (irq_o && !irq_ack_i
        |=> irq_o && $stable(irq_vector_o)) else $error("request dropped before ack");
    AST_IRQ_ACK: assert property (irq_o && irq_ack_i
        |=> !irq_o) else $error("request stands after ack");
    AST_VEC: assert property (irq_o |-> irq_vector_o == `ICDR_VEC_FIRST ||
        irq_vector_o == `ICDR_VEC_FIRST + 7'h01) else $error("vector out of range");
    AST_BAD_ADDR: assert property (psel_i && penable_i && paddr_i[1:0] != 2'h0
        |-> pslverr_o) else $error("misaligned access not refused");
    AST_ERR_GATE: assert property (!(psel_i && penable_i) |-> !pslverr_o)
        else $error("error outside access phase");
endmodule

bind icdr_collector icdr_collector_asserts chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .irq_ack_i(irq_ack_i),
    .irq_o(irq_o), .irq_vector_o(irq_vector_o), .debug_flag_o(debug_flag_o));

// file: tb/test_icdr_collector.sv
// self-checking bench for the interrupt collector with a core model
// assumes rtl/ on the include path; 100 MHz clock, reset low for 4 cycles
`include "icdr_consts.svh"
module test_icdr_collector;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [12:0] S7 = `ICDR_OFS_SRC117;
    localparam logic [12:0] S8 = `ICDR_OFS_SRC118;
    logic                 clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic                 irq_ack_i, irq_done_i, irq_o, fast_o;
    logic [12:0]          paddr_i;
    logic [31:0]          pwdata_i, prdata_o, debug_flag_o;
    logic [1:0]           src_req_i, last_lvl;
    logic [6:0]           irq_vector_o, last_vec;
    icdr_pkg::icdr_prio_t irq_level_o;
    logic [3:0]           dly;
    logic [7:0]           svc_cnt;
    int                   n_fail = 0;
    int                   comparisons = 0;

    icdr_collector dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .src_req_i(src_req_i), .irq_ack_i(irq_ack_i), .irq_done_i(irq_done_i), .irq_o(irq_o),
        .irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o),
        .fast_interrupt_line_o(fast_o), .debug_flag_o(debug_flag_o));
    icdr_core_model core_u (.clk_i(clk_i), .nrst_i(nrst_i), .irq_i(irq_o),
        .vec_i(irq_vector_o), .lvl_i(irq_level_o), .dly_i(dly), .ack_o(irq_ack_i),
        .done_o(irq_done_i), .svc_cnt_o(svc_cnt), .vec_o(last_vec), .lvl_o(last_lvl));

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one setup and one access phase; answer taken at the closing edge
    task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        @(posedge clk_i);
        while (pready_o !== 1'h1) @(posedge clk_i);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'h1, a, d, r, e);
    endtask

    task automatic rdc(input logic [12:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        xfer(1'h0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask

    // wait for one service by the core and check what it was handed
    task automatic svc(input logic [6:0] v, input logic [1:0] l);
        logic [7:0] b;
        b = svc_cnt;
        for (int i = 0; i < 60 && svc_cnt === b; i++) @(posedge clk_i);
        chk({24'h0, svc_cnt - b}, 32'h1);
        chk({25'h0, last_vec}, {25'h0, v});
        chk({30'h0, last_lvl}, {30'h0, l});
    endtask

    // no new service may start once the current one has drained
    task automatic quiet();
        logic [7:0] b;
        repeat (20) @(posedge clk_i);
        b = svc_cnt;
        repeat (40) @(posedge clk_i);
        chk({24'h0, svc_cnt}, {24'h0, b});
    endtask

    task automatic test_done();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        test_done();
    end

    initial begin
        {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, src_req_i} = '0;
        dly = 4'h0;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'h1;
        chk({31'h0, irq_o | fast_o}, 32'h0);
        chk({31'h0, pready_o}, 32'h1);
        rdc(`ICDR_OFS_STAT, 32'h00007501, 1'h0);
        rdc(S7, 32'h0, 1'h0);
        rdc(S8, 32'h0, 1'h0);
        rdc(`ICDR_OFS_DBG_A, `ICDR_DBG_A_VALUE, 1'h0);
        wr(`ICDR_OFS_DBG_B, 32'h0);
        rdc(`ICDR_OFS_DBG_B, `ICDR_DBG_B_VALUE, 1'h0);
        wr(S8, 32'h1B);
        rdc(S8, 32'h1B, 1'h0);
        wr(S8 + 13'h8, 32'h1A);
        rdc(S8 + 13'h4, 32'h01, 1'h0);
        wr(S8 + 13'h4, 32'h12);
        rdc(S8 + 13'hC, 32'h13, 1'h0);
        wr(S8 + 13'hC, 32'h11);
        rdc(S8, 32'h02, 1'h0);
        wr(S8, 32'h0);
        rdc(13'h0900, 32'h0, 1'h1);
        rdc(13'h0882, 32'h0, 1'h1);
        wr(`ICDR_OFS_FLAG, 32'hA5C30F96);
        rdc(`ICDR_OFS_FLAG, 32'hA5C30F96, 1'h0);
        chk(debug_flag_o, 32'hA5C30F96);
        chk({31'h0, irq_o}, 32'h0);
        wr(S7, 32'h0E);
        svc(`ICDR_VEC_FIRST, 2'h2);
        wr(S7 + 13'h8, 32'h08);
        quiet();
        wr(S7, 32'h0A);
        src_req_i <= 2'h1;
        quiet();
        src_req_i <= 2'h0;
        wr(S7, 32'h03);
        wr(S8, 32'h01);
        wr(S7, 32'h07);
        wr(S8, 32'h05);
        src_req_i <= 2'h3;
        svc(`ICDR_VEC_FIRST, 2'h3);
        src_req_i <= 2'h0;
        quiet();
        wr(S7 + 13'h8, 32'h04);
        wr(S8 + 13'h8, 32'h04);
        wr(S7, 32'h04);
        wr(S8, 32'h06);
        dly = 4'h4;
        src_req_i <= 2'h3;
        svc(`ICDR_VEC_FIRST + 7'h01, 2'h2);
        src_req_i <= 2'h0;
        quiet();
        wr(S7, 32'h0);
        wr(S8, 32'h16);
        src_req_i <= 2'h2;
        repeat (3) @(posedge clk_i);
        chk({31'h0, fast_o}, 32'h1);
        rdc(`ICDR_OFS_STAT, 32'h00227601, 1'h0);
        quiet();
        src_req_i <= 2'h0;
        repeat (3) @(posedge clk_i);
        chk({31'h0, fast_o}, 32'h0);
        test_done();
    end
endmodule
